// ==== edd_ctrl.sv ====
/*
 * Control decoder of a serially programmed echo/delay unit: three-wire
 * serial port, two-entry word buffer, setting decode, sample-rate
 * divider, auto mute, and a classic Wishbone register slave.
 * Assumes a 20 MHz system clock; serial pins are asynchronous.
 */
// Design decisions made here: register access over Wishbone and the address map.
// Operation
// - Delay code picks one of eight delays and the sample divisor 6/6/6/6/6/12/18/24.
// - Delay gain code steps from +3 dB down by 3 dB, code 7 silences.
// - Feedback gain code steps from -3 dB down by 2 dB, code 7 cuts off.
// - Delays up to 48 ms use the short filter switch, longer ones the long.
// - Delay output is muted at power-up and when the delay setting changes.
// - Input and output path selectors route the mixed inputs.
// - Each transfer is one 16-bit word applied as one update.
// - Serial data is captured on every rising shift-clock edge.
// - A rising latch strobe moves the shifted word into the settings.
`timescale 1ns/1ps
`default_nettype none
`include "edd_regs.svh"
module edd_ctrl #(
   parameter int MUTE_SAMPLES = `EDD_MUTE_SAMPLES
) (
   input wire logic clk_sys_in,               // 20 MHz system clock
   input wire logic rst_in,                   // async reset, high
   input wire logic [3:0] wb_adr_in,          // byte address
   input wire logic [31:0] wb_dat_in,         // write data
   output logic [31:0] wb_dat_out,            // read data
   input wire logic [3:0] wb_sel_in,          // byte lanes
   input wire logic wb_we_in,                 // write
   input wire logic wb_cyc_in,                // cycle
   input wire logic wb_stb_in,                // strobe
   output logic wb_ack_out,                   // acknowledge
   input wire logic shift_clock_in,           // serial shift clock pin
   input wire logic serial_data_in,           // serial data pin
   input wire logic latch_strobe_in,          // serial latch pin
   output edd_pkg::edd_word_t ctrl_word_out,  // active word
   output logic [2:0] delay_code_out,         // delay select
   output logic sample_tick_out,              // sample-rate pulse
   output logic [2:0] delay_gain_code_out,    // delay gain code
   output logic [2:0] feedback_gain_code_out, // feedback gain code
   output logic [5:0] delay_gain_db_out,      // signed dB
   output logic [5:0] feedback_gain_db_out,   // signed dB
   output logic delay_silent_out,             // delay path off
   output logic feedback_cut_out,             // feedback off
   output logic short_delay_filter_switch_out, // 7 kHz resistor
   output logic long_delay_filter_switch_out,  // 3 kHz resistor
   output logic [1:0] input_path_select_out,  // mixer input path
   output logic [1:0] output_path_select_out, // mixer output path
   output logic delay_mute_out                // delay output muted
);
   import edd_pkg::*;
   localparam int MW = $clog2(MUTE_SAMPLES + 1);
   localparam int DW = $clog2(`EDD_MCLK_DIV);

   // pin synchronisers: a change counts once stages two and three agree
   wire [2:0] pin_raw = {latch_strobe_in, serial_data_in, shift_clock_in};
   logic [2:0] s1, s2, s3, flt, flt_q;
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
         if (rst_in) begin
            s1[i] <= 1'b0;
            s2[i] <= 1'b0;
            s3[i] <= 1'b0;
            flt[i] <= 1'b0;
            flt_q[i] <= 1'b0;
         end else begin
            s1[i] <= pin_raw[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
            flt[i] <= (s2[i] == s3[i]) ? s3[i] : flt[i];
            flt_q[i] <= flt[i];
         end
      end
   end
   wire sck_rise = flt[0] & ~flt_q[0];
   wire lat_rise = flt[2] & ~flt_q[2];

   edd_word_t shreg, word, buf_word, sw_word, push_word;
   logic in_ready, out_valid, mclk_en, ovr, force_mute, ack;
   logic [DW-1:0] mdiv;
   logic [4:0] sdiv;
   logic [MW-1:0] mute_cnt;
   edd_mute_state_t state, next_state;

   // bit 0 arrives first and ends up in bit 0 after sixteen edges
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         shreg <= '0;
      end else if (sck_rise) begin
         shreg <= {flt[1], shreg[15:1]};
      end
   end

   // bus decode
   wire wb_hit = wb_cyc_in & wb_stb_in & ~ack;
   wire wr = wb_hit & wb_we_in;
   wire sel_ctrl = (wb_adr_in == `EDD_OFF_CTRL);
   wire sel_stat = (wb_adr_in == `EDD_OFF_STATUS);
   wire sel_force = (wb_adr_in == `EDD_OFF_FORCE);
   wire sw_push = wr & sel_ctrl & (|wb_sel_in[1:0]);
   assign sw_word = {wb_sel_in[1] ? wb_dat_in[15:8] : word[15:8],
                     wb_sel_in[0] ? wb_dat_in[7:0] : word[7:0]};

   // the pin wins a same-cycle collision; the lost bus word flags overrun
   wire push_valid = lat_rise | sw_push;
   assign push_word = lat_rise ? shreg : sw_word;
   wire ovr_set = (push_valid & ~in_ready) | (lat_rise & sw_push);
   wire ovr_clr = wr & sel_stat & wb_sel_in[0] & wb_dat_in[`EDD_ST_OVR];

   edd_buf #(.W(16), .DEPTH(2)) u_buf (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .in_valid_in(push_valid),
      .in_ready_out(in_ready),
      .in_data_in(push_word),
      .out_valid_out(out_valid),
      .out_ready_in(mclk_en),
      .out_data_out(buf_word)
   );

   // words are taken only on master-clock beats, so the buffer can fill
   wire apply = out_valid & mclk_en;
   wire edd_word_t next_word = apply ? buf_word : word;
   wire [2:0] nd = next_word[`EDD_F_DELAY +: 3];
   wire [2:0] ng = next_word[`EDD_F_DGAIN +: 3];
   wire [2:0] nf = next_word[`EDD_F_FBGAIN +: 3];
   wire delay_chg = apply & (nd != word[`EDD_F_DELAY +: 3]);

   // sample divisor in master clocks: 6 up to code 4, then 6*(code-3)
   wire [2:0] cd = word[`EDD_F_DELAY +: 3];
   // widen before the product: a 3-bit product wraps for codes 5 to 7
   wire [4:0] div_long = (5'(cd) - 5'(`EDD_LONG_BASE)) * `EDD_DIV_BASE;
   wire [4:0] sdiv_top = (cd <= `EDD_SHORT_MAX) ? `EDD_DIV_BASE : div_long;
   wire clk_off = (word[`EDD_F_INPUT_PATH_SELECT +: 2] == `EDD_INPUT_PATH_SELECT_CLKOFF);
   wire samp = mclk_en & (sdiv == sdiv_top - 5'h01) & ~clk_off;

   // a change restarts the count; the full memory length covers every code
   always_comb begin
      next_state = state;
      if (delay_chg) begin
         next_state = EDD_MUTED;
      end else if (state == EDD_MUTED && samp &&
                   mute_cnt == MW'(MUTE_SAMPLES - 1)) begin
         next_state = EDD_RUN;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         mdiv <= '0;
         mclk_en <= 1'b0;
         sdiv <= '0;
      end else begin
         mclk_en <= (mdiv == DW'(`EDD_MCLK_DIV - 1));
         mdiv <= (mdiv == DW'(`EDD_MCLK_DIV - 1)) ? '0 : mdiv + 1'b1;
         if (delay_chg || samp) begin
            sdiv <= '0;
         end else if (mclk_en) begin
            sdiv <= sdiv + 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state <= EDD_MUTED;
         mute_cnt <= '0;
      end else begin
         state <= next_state;
         if (delay_chg) begin
            mute_cnt <= '0;
         end else if (state == EDD_MUTED && samp) begin
            mute_cnt <= mute_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         word <= `EDD_WORD_RST;
         ovr <= 1'b0;
         force_mute <= 1'b0;
         ack <= 1'b0;
         wb_dat_out <= '0;
      end else begin
         word <= next_word;
         ovr <= ovr_set | (ovr & ~ovr_clr);
         if (wr && sel_force && wb_sel_in[0]) begin
            force_mute <= wb_dat_in[0];
         end
         ack <= wb_hit;
         if (wb_hit) begin
            wb_dat_out <= sel_ctrl ? {16'h0000, word} :
                          sel_stat ? {29'h0, ~in_ready, ovr,
                                      state == EDD_MUTED} :
                          sel_force ? {31'h0, force_mute} : 32'h0;
         end
      end
   end
   assign wb_ack_out = ack;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_word_out <= `EDD_WORD_RST;
         delay_code_out <= '0;
         sample_tick_out <= 1'b0;
         delay_gain_code_out <= '0;
         feedback_gain_code_out <= '0;
         delay_gain_db_out <= `EDD_DGAIN_TOP;
         feedback_gain_db_out <= `EDD_FGAIN_TOP;
         delay_silent_out <= 1'b1;
         feedback_cut_out <= 1'b0;
         short_delay_filter_switch_out <= 1'b1;
         long_delay_filter_switch_out <= 1'b0;
         input_path_select_out <= '0;
         output_path_select_out <= '0;
         delay_mute_out <= 1'b1;
      end else begin
         ctrl_word_out <= next_word;
         delay_code_out <= nd;
         sample_tick_out <= samp;
         delay_gain_code_out <= ng;
         feedback_gain_code_out <= nf;
         delay_gain_db_out <= `EDD_DGAIN_TOP -
                              6'(ng) * `EDD_DGAIN_STEP;
         feedback_gain_db_out <= `EDD_FGAIN_TOP -
                                 6'(nf) * `EDD_FGAIN_STEP;
         delay_silent_out <= (ng == `EDD_CODE_SILENT) |
                             (next_state == EDD_MUTED);
         feedback_cut_out <= (nf == `EDD_CODE_SILENT);
         short_delay_filter_switch_out <= (nd <= `EDD_SHORT_MAX);
         long_delay_filter_switch_out <= (nd > `EDD_SHORT_MAX);
         input_path_select_out <= next_word[`EDD_F_INPUT_PATH_SELECT +: 2];
         output_path_select_out <= next_word[`EDD_F_OUTPUT_PATH_SELECT +: 2];
         // output switch off and software force also hold the mute
         delay_mute_out <= (next_state == EDD_MUTED) | force_mute |
                           ~next_word[`EDD_F_DOUT];
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   sequence s_change;
      delay_chg;
   endsequence
   sequence s_muted_after;
      delay_mute_out && delay_silent_out;
   endsequence

   chk_change_mute: assert property (s_change |=> s_muted_after)
      else $error("delay change did not mute the delay output");
   chk_mute_hold: assert property ($rose(state == EDD_MUTED)
      |-> ##1 (state == EDD_MUTED) [*8])
      else $error("mute released too early");
   chk_tick_space: assert property (sample_tick_out
      |=> !sample_tick_out [*8])
      else $error("sample ticks too close together");
   chk_fb_cut: assert property (feedback_gain_code_out == 3'h7
      |-> feedback_cut_out)
      else $error("feedback code 7 did not cut feedback");
   chk_filter_pick: assert property (short_delay_filter_switch_out ==
      (delay_code_out <= 3'h4) && (short_delay_filter_switch_out !=
      long_delay_filter_switch_out))
      else $error("filter switch does not match delay code");
   chk_gain_step: assert property (delay_gain_code_out == 3'h1
      |-> delay_gain_db_out == 6'h00)
      else $error("delay gain code 1 is not 0 dB");
   chk_shift_in: assert property (sck_rise
      |=> shreg == {$past(flt[1]), $past(shreg[15:1])})
      else $error("serial bit not captured on shift edge");
   chk_latch_apply: assert property (lat_rise && in_ready && !out_valid
      |-> ##[1:12] apply)
      else $error("latched word not applied");
   chk_clk_off: assert property (input_path_select_out == 2'h3
      && $stable(input_path_select_out) |-> !sample_tick_out)
      else $error("sample tick while clock is off");
endmodule
`default_nettype wire

// ==== edd_regs.svh ====
/*
 * Constants of the echo/delay control decoder: rates, offsets, field
 * positions, reset values and step tables.
 * Assumes inclusion by bare name from the controller and bench files.
 */
`ifndef EDD_REGS_SVH
`define EDD_REGS_SVH

`define EDD_SYS_HZ 20000000
`define EDD_MCLK_HZ 2000000
`define EDD_MCLK_DIV (`EDD_SYS_HZ / `EDD_MCLK_HZ)
`define EDD_MUTE_SAMPLES 16000

`define EDD_OFF_CTRL 4'h0
`define EDD_OFF_STATUS 4'h4
`define EDD_OFF_FORCE 4'h8

`define EDD_F_DELAY 0
`define EDD_F_INPUT_PATH_SELECT 3
`define EDD_F_OUTPUT_PATH_SELECT 5
`define EDD_F_DOUT 7
`define EDD_F_DGAIN 8
`define EDD_F_FBGAIN 11

`define EDD_ST_MUTED 0
`define EDD_ST_OVR 1
`define EDD_ST_FULL 2

`define EDD_WORD_RST 16'h0000
`define EDD_CODE_SILENT 3'h7
`define EDD_SHORT_MAX 3'h4
`define EDD_DIV_BASE 5'h06
`define EDD_LONG_BASE 3'h3
`define EDD_INPUT_PATH_SELECT_CLKOFF 2'h3

`define EDD_DGAIN_TOP 6'h03
`define EDD_DGAIN_STEP 6'h03
`define EDD_FGAIN_TOP 6'h3d
`define EDD_FGAIN_STEP 6'h02

`endif

// ==== edd_pkg.sv ====
/*
 * Types shared by the echo/delay control decoder.
 * Assumes edd_regs.svh is on the include path.
 */
package edd_pkg;
   typedef logic [15:0] edd_word_t;
   typedef enum {EDD_RUN, EDD_MUTED} edd_mute_state_t;
endpackage

// ==== edd_buf.sv ====
/*
 * Two-entry word buffer with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module edd_buf #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys_in,          // system clock
   input wire logic rst_in,              // async reset, high
   input wire logic in_valid_in,         // word offered
   output logic in_ready_out,            // room for a word
   input wire logic [W-1:0] in_data_in,  // offered word
   output logic out_valid_out,           // word waiting
   input wire logic out_ready_in,        // drain takes word
   output logic [W-1:0] out_data_out     // oldest word
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wp, rp;
   logic [PW:0] cnt;
   wire do_wr = in_valid_in & in_ready_out;
   wire do_rd = out_valid_out & out_ready_in;

   assign in_ready_out = (cnt != (PW+1)'(DEPTH));
   assign out_valid_out = (cnt != '0);
   assign out_data_out = mem[rp];

   always_ff @(posedge clk_sys_in) begin
      if (do_wr) begin
         mem[wp] <= in_data_in;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         wp <= do_wr ? wp + 1'b1 : wp;
         rp <= do_rd ? rp + 1'b1 : rp;
         cnt <= cnt + (PW+1)'(do_wr) - (PW+1)'(do_rd);
      end
   end
endmodule
`default_nettype wire

// ==== edd_host.sv ====
/* host model that drives the three-wire serial control port.
   assumes the system clock paces every level change. */
`timescale 1ns/1ps
`default_nettype none
module edd_host (
   input wire logic clk_sys_in, // system clock
   output logic shift_clock_out, // serial shift clock
   output logic serial_data_out, // serial data
   output logic latch_strobe_out // latch strobe
);
   initial begin
      shift_clock_out = 1'b0;
      serial_data_out = 1'b0;
      latch_strobe_out = 1'b0;
   end
   // hold: cycles per level; the clock idles low between frames
   task automatic send_word(input logic [15:0] w, input int hold);
      for (int i = 0; i < 16; i++) begin
         serial_data_out <= w[i];
         shift_clock_out <= 1'b0;
         repeat (hold) @(posedge clk_sys_in);
         shift_clock_out <= 1'b1;
         repeat (hold) @(posedge clk_sys_in);
      end
      shift_clock_out <= 1'b0;
      // data line has no pull: show the inverse once released
      serial_data_out <= ~w[15];
      repeat (hold) @(posedge clk_sys_in);
      latch_strobe_out <= 1'b1;
      repeat (hold) @(posedge clk_sys_in);
      latch_strobe_out <= 1'b0;
      repeat (hold) @(posedge clk_sys_in);
   endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
/* self-checking bench of the echo/delay control decoder.
   assumes edd_pkg, edd_buf, edd_ctrl and edd_host are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "edd_regs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
   $display("BAD %s exp %h got %h", nm, ex, got); fails++; end end
module testbench;
   import edd_pkg::*;
   logic clk_sys_in = 1'b0, rst_in = 1'b1;
   logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
   logic wb_we_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_ack_out;
   wire shift_clock_in, serial_data_in, latch_strobe_in;
   edd_word_t ctrl_word_out;
   logic [2:0] delay_code_out, delay_gain_code_out, feedback_gain_code_out;
   logic [5:0] delay_gain_db_out, feedback_gain_db_out;
   logic [1:0] input_path_select_out, output_path_select_out;
   logic sample_tick_out, delay_silent_out, feedback_cut_out, delay_mute_out;
   logic short_delay_filter_switch_out, long_delay_filter_switch_out;
   int fails = 0, num_checks = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   // short mute count keeps the run brief; the mute_len check expects at least 3 of its 4 ticks
   edd_ctrl #(.MUTE_SAMPLES(4)) dut_u (.clk_sys_in, .rst_in, .wb_adr_in,
      .wb_dat_in, .wb_dat_out, .wb_sel_in, .wb_we_in, .wb_cyc_in,
      .wb_stb_in, .wb_ack_out, .shift_clock_in, .serial_data_in,
      .latch_strobe_in, .ctrl_word_out, .delay_code_out, .sample_tick_out,
      .delay_gain_code_out, .feedback_gain_code_out, .delay_gain_db_out,
      .feedback_gain_db_out, .delay_silent_out, .feedback_cut_out,
      .short_delay_filter_switch_out, .long_delay_filter_switch_out,
      .input_path_select_out, .output_path_select_out, .delay_mute_out);
   edd_host host_u (.clk_sys_in, .shift_clock_out(shift_clock_in),
      .serial_data_out(serial_data_in), .latch_strobe_out(latch_strobe_in));
   task test_done;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= d;
      wb_sel_in <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 20);
      rd = wb_dat_out;
      if (wb_ack_out !== 1'b1) begin
         fails++;
         test_done();
      end
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (sample_tick_out !== 1'b1 && n < 400);
      if (sample_tick_out !== 1'b1) begin
         fails++;
         test_done();
      end
   endtask
   function automatic int divisor(input logic [2:0] c);
      return (c <= 3'h4) ? 6 : (int'(c) - 3) * 6;
   endfunction
   task automatic apply(input logic [15:0] w, input bit ser);
      if (ser)
         host_u.send_word(w, 4 + 5 * $urandom_range(1));
      else
         wb(1'b1, `EDD_OFF_CTRL, {16'h0, w});
      repeat (30) @(posedge clk_sys_in);
   endtask
   task automatic check(input logic [15:0] w);
      `CHK("word", w, ctrl_word_out)
      `CHK("delay", w[2:0], delay_code_out)
      `CHK("short", w[2:0] <= 3'h4, short_delay_filter_switch_out)
      `CHK("long", w[2:0] > 3'h4, long_delay_filter_switch_out)
      `CHK("dgain", w[10:8], delay_gain_code_out)
      `CHK("ddb", 6'(3 - 3 * int'(w[10:8])), delay_gain_db_out)
      `CHK("fgain", w[13:11], feedback_gain_code_out)
      `CHK("fdb", 6'(-3 - 2 * int'(w[13:11])), feedback_gain_db_out)
      `CHK("cut", w[13:11] == 3'h7, feedback_cut_out)
      `CHK("input_path_select", w[4:3], input_path_select_out)
      `CHK("output_path_select", w[6:5], output_path_select_out)
   endtask
   initial begin
      int t, n;
      logic [15:0] w;
      void'($urandom(32'h895b0cb4));
      repeat (16) @(posedge clk_sys_in);
      `CHK("mute0", 1'b1, delay_mute_out)
      `CHK("silent0", 1'b1, delay_silent_out)
      `CHK("short0", 1'b1, short_delay_filter_switch_out)
      `CHK("ddb0", 6'h03, delay_gain_db_out)
      `CHK("fdb0", 6'h3d, feedback_gain_db_out)
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      wb(1'b0, 4'hc, 32'hffffffff);
      `CHK("unmapped", 32'h0, rd)
      wb(1'b0, `EDD_OFF_STATUS, 32'h0);
      `CHK("st_mute", 1'b1, rd[`EDD_ST_MUTED])
      for (int i = 0; i < 8; i++) begin
         w = 16'($urandom);
         w[15] = 1'b0;
         w[2:0] = 3'(i);
         w[7] = 1'b1;
         w[10:8] = 3'(i);
         w[13:11] = 3'(7 - i);
         if (w[4:3] == `EDD_INPUT_PATH_SELECT_CLKOFF)
            w[4:3] = 2'h0;
         apply(w, i[0]);
         check(w);
         `CHK("mute_chg", 1'b1, delay_mute_out)
         `CHK("silent_chg", 1'b1, delay_silent_out)
         n = 0;
         t = 0;
         while (delay_mute_out === 1'b1 && t < 4000) begin
            @(posedge clk_sys_in);
            t++;
            if (sample_tick_out === 1'b1)
               n++;
         end
         // one tick may fall in the settling wait before counting starts
         `CHK("mute_len", 1'b1, n >= 3)
         `CHK("unmuted", 1'b0, delay_mute_out)
         `CHK("silent", w[10:8] == 3'h7, delay_silent_out)
         wait_tick(t);
         wait_tick(t);
         `CHK("period", divisor(3'(i)) * 10, t)
      end
      // writes outpace the master-clock drain and overrun the buffer
      for (int i = 0; i < 6; i++)
         wb(1'b1, `EDD_OFF_CTRL, 32'h80 | i);
      wb(1'b0, `EDD_OFF_STATUS, 32'h0);
      `CHK("overrun", 1'b1, rd[`EDD_ST_OVR])
      wb(1'b1, `EDD_OFF_STATUS, 32'h2);
      wb(1'b0, `EDD_OFF_STATUS, 32'h0);
      `CHK("ovr_clr", 1'b0, rd[`EDD_ST_OVR])
      // let the burst drain so both following words fit the buffer
      repeat (30) @(posedge clk_sys_in);
      wb(1'b1, `EDD_OFF_CTRL, 32'h1a81);
      wb(1'b1, `EDD_OFF_CTRL, 32'h2c82);
      repeat (40) @(posedge clk_sys_in);
      check(16'h2c82);
      // the auto mute must be over, or the force check cannot fail
      t = 0;
      while (delay_mute_out === 1'b1 && t < 2000) begin
         @(posedge clk_sys_in);
         t++;
      end
      `CHK("unmuted2", 1'b0, delay_mute_out)
      wb(1'b1, `EDD_OFF_FORCE, 32'h1);
      repeat (3) @(posedge clk_sys_in);
      `CHK("force", 1'b1, delay_mute_out)
      wb(1'b1, `EDD_OFF_FORCE, 32'h0);
      repeat (3) @(posedge clk_sys_in);
      `CHK("unforce", 1'b0, delay_mute_out)
      apply(16'h1898, 1'b0);
      n = 0;
      repeat (300) begin
         @(posedge clk_sys_in);
         if (sample_tick_out === 1'b1)
            n++;
      end
      `CHK("clk_off", 0, n)
      test_done();
   end
endmodule
`default_nettype wire
